// File: cfd_pkg.sv
// constants, field positions and decode helpers for the configuration bank
`default_nettype none
package cfd_pkg;

    // ----------------------------------------------------------------
    // byte addresses of the configuration space
    // ----------------------------------------------------------------
    localparam logic [21:0] CFD_CFG_BASE = 22'h30_0000;
    localparam logic [21:0] CFD_CFG_LAST = 22'h30_00FF;
    localparam logic [21:0] CFD_A_WDT = 22'h30_0003;
    localparam logic [21:0] CFD_A_BUS = 22'h30_0004;
    localparam logic [21:0] CFD_A_PIN = 22'h30_0005;
    localparam logic [21:0] CFD_A_DBG = 22'h30_0006;
    localparam logic [21:0] CFD_A_CPL = 22'h30_0008;
    localparam logic [21:0] CFD_A_CPH = 22'h30_0009;
    localparam logic [21:0] CFD_A_WPL = 22'h30_000A;
    localparam logic [21:0] CFD_A_WPH = 22'h30_000B;

    // ----------------------------------------------------------------
    // storage slots, masks and unprogrammed values
    // ----------------------------------------------------------------
    localparam logic [2:0] CFD_I_WDT = 3'h0;
    localparam logic [2:0] CFD_I_BUS = 3'h1;
    localparam logic [2:0] CFD_I_PIN = 3'h2;
    localparam logic [2:0] CFD_I_DBG = 3'h3;
    localparam logic [2:0] CFD_I_CPL = 3'h4;
    localparam logic [2:0] CFD_I_CPH = 3'h5;
    localparam logic [2:0] CFD_I_WPL = 3'h6;
    localparam logic [2:0] CFD_I_WPH = 3'h7;
    // implemented bits per slot, slot 7 first
    localparam logic [7:0][7:0] CFD_IMPL_MASK = {
        8'hE0, 8'h0F, 8'hC0, 8'h0F, 8'h85, 8'h83, 8'h83, 8'h1F};
    // blank part: every implemented bit reads one
    localparam logic [7:0][7:0] CFD_UNPROG = CFD_IMPL_MASK;
    // slots whose bits may only be cleared
    localparam logic [7:0] CFD_CLEAR_ONLY = 8'hF0;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CFD_B_WDT_FORCE = 0;
    localparam int CFD_B_PS_LO = 1;
    localparam int CFD_B_BUS_WAIT = 7;
    localparam int CFD_B_MODE_LO = 0;
    localparam int CFD_B_RST_PIN = 7;
    localparam int CFD_B_ENH_PWM = 1;
    localparam int CFD_B_CAP2 = 0;
    localparam int CFD_B_DEBUG = 7;
    localparam int CFD_B_LV_PROG = 2;
    localparam int CFD_B_STACK = 0;
    localparam int CFD_B_EEP = 7;
    localparam int CFD_B_BOOT = 6;
    localparam int CFD_B_CFGW = 5;

    // ----------------------------------------------------------------
    // processor memory modes
    // ----------------------------------------------------------------
    localparam logic [1:0] CFD_MODE_MCU = 2'h3;
    localparam logic [1:0] CFD_MODE_MPU = 2'h2;
    localparam logic [1:0] CFD_MODE_MPU_BOOT = 2'h1;
    localparam logic [1:0] CFD_MODE_EXT_MCU = 2'h0;

    // ----------------------------------------------------------------
    // self-timed write
    // ----------------------------------------------------------------
    localparam int CFD_CLK_PERIOD_NS = 20;
    localparam int CFD_WRITE_TIME_NS = 2000;
    // least time, rounded up to whole cycles
    localparam int CFD_WRITE_CYCLES =
        (CFD_WRITE_TIME_NS + CFD_CLK_PERIOD_NS - 1) / CFD_CLK_PERIOD_NS;
    localparam logic [7:0] CFD_WRITE_LAST = 8'(CFD_WRITE_CYCLES - 1);

    typedef enum logic {CFD_IDLE, CFD_WRITE} cfd_state_e;

    // address to {hit, slot}
    function automatic logic [3:0] cfd_slot(input logic [21:0] a);
        case (a)
            CFD_A_WDT: cfd_slot = {1'b1, CFD_I_WDT};
            CFD_A_BUS: cfd_slot = {1'b1, CFD_I_BUS};
            CFD_A_PIN: cfd_slot = {1'b1, CFD_I_PIN};
            CFD_A_DBG: cfd_slot = {1'b1, CFD_I_DBG};
            CFD_A_CPL: cfd_slot = {1'b1, CFD_I_CPL};
            CFD_A_CPH: cfd_slot = {1'b1, CFD_I_CPH};
            CFD_A_WPL: cfd_slot = {1'b1, CFD_I_WPL};
            CFD_A_WPH: cfd_slot = {1'b1, CFD_I_WPH};
            default: cfd_slot = 4'h0;
        endcase
    endfunction

endpackage
`default_nettype wire

// File: cfd_fuse_bank.sv
// configuration byte bank with its decoders and protection outputs
//
// Summary of operation
// - watchdog postscaler code n in bits 4:1 gives divide ratio 2^n.
// - bit 0 set forces watchdog on; clear lets software enable decide.
// - unimplemented bits of every configuration byte read as zero.
// - implemented bits read one while the part is unprogrammed.
// - bus-wait bit set disables table wait states; clear uses wait field.
// - mode field: 11 mcu, 10 mpu, 01 mpu with boot, 00 extended mcu.
// - reset-pin bit set makes pin a reset input, else a port input.
// - pwm mux bit picks port E pins 6-3 (1) or port H pins 7-4 (0).
// - capture2 to port C1 when set, else E7 in mcu or B3 otherwise.
// - debugger bit clear dedicates port B pins 6 and 7 to debug.
// - low-voltage programming bit set enables low-voltage entry.
// - stack-error bit set turns stack full or underflow into reset.
// - four code-protect bits guard four program blocks; zero protects.
// - boot code-protect bit clear protects the boot region.
// - eeprom code-protect bit clear protects data eeprom.
// - four write-protect bits guard the same blocks; zero protects.
// - eeprom write-protect bit clear blocks eeprom writes.
// - boot write-protect bit clear blocks boot region writes.
// - config write-protect bit clear blocks writes to config space.
// - protection bits can only be cleared, never set back by a write.
// - programmed reads zero, blank reads one; bytes sit from 300000h.
// - one byte per write: load address and data, then start timed write.
`timescale 1ns/1ps
`default_nettype none
module cfd_fuse_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [21:0] tbl_addr,
    input wire logic [7:0] tbl_wdata,
    input wire logic tbl_write,
    input wire logic write_start,
    input wire logic rd_en,
    input wire logic [21:0] rd_addr,
    input wire logic watchdog_soft_on,
    input wire logic [1:0] bus_wait_count,
    input wire logic master_reset_pin_n,
    input wire logic port_g_pin5,
    input wire logic stack_fault,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    output logic write_busy_q,
    output logic write_refused_q,
    output logic [3:0] watchdog_postscale_sel_q,
    output logic [15:0] watchdog_ratio_q,
    output logic watchdog_on_q,
    output logic tbl_wait_en_q,
    output logic [1:0] tbl_wait_states_q,
    output logic [1:0] processor_mode_sel_q,
    output logic pin_reset_req_q,
    output logic port_g_pin5_in_q,
    output logic enh_pwm_on_port_e_q,
    output logic enh_pwm_on_port_h_q,
    output logic capture2_on_c1_q,
    output logic capture2_on_e7_q,
    output logic capture2_on_b3_q,
    output logic debug_pins_dedicated_q,
    output logic low_volt_prog_enable_q,
    output logic stack_reset_req_q,
    output logic [3:0] block_code_protect_q,
    output logic boot_code_protect_q,
    output logic eeprom_code_protect_q,
    output logic [3:0] block_write_protect_q,
    output logic boot_write_protect_q,
    output logic eeprom_write_protect_q,
    output logic config_write_protect_q
);

    // ----------------------------------------------------------------
    // storage and write sequencer state
    // ----------------------------------------------------------------
    logic [7:0][7:0] cfg_q;
    logic [21:0] ld_addr_q;
    logic [7:0] ld_data_q;
    cfd_pkg::cfd_state_e state_q;
    logic [7:0] cnt_q;
    logic [1:0] rst_pin_sync_q;
    logic [1:0] g5_sync_q;
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic wr_in_cfg;
    logic wr_blocked;
    logic commit;
    logic [7:0] wdt_b, bus_b, pin_b, dbg_b;
    logic [7:0] cpl_b, cph_b, wpl_b, wph_b;

    assign wdt_b = cfg_q[cfd_pkg::CFD_I_WDT];
    assign bus_b = cfg_q[cfd_pkg::CFD_I_BUS];
    assign pin_b = cfg_q[cfd_pkg::CFD_I_PIN];
    assign dbg_b = cfg_q[cfd_pkg::CFD_I_DBG];
    assign cpl_b = cfg_q[cfd_pkg::CFD_I_CPL];
    assign cph_b = cfg_q[cfd_pkg::CFD_I_CPH];
    assign wpl_b = cfg_q[cfd_pkg::CFD_I_WPL];
    assign wph_b = cfg_q[cfd_pkg::CFD_I_WPH];

    // target decode of the loaded write
    assign wr_slot = cfd_pkg::cfd_slot(ld_addr_q);
    assign rd_slot = cfd_pkg::cfd_slot(rd_addr);
    assign wr_in_cfg = (ld_addr_q >= cfd_pkg::CFD_CFG_BASE) &&
                       (ld_addr_q <= cfd_pkg::CFD_CFG_LAST);
    assign wr_blocked = wr_in_cfg && !wph_b[cfd_pkg::CFD_B_CFGW];
    assign commit = (state_q == cfd_pkg::CFD_WRITE) && (cnt_q == 8'h00);

    // ----------------------------------------------------------------
    // table write staging
    // ----------------------------------------------------------------
    // address and data latch
    // a load during a running write is held off so the cell stays coherent
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ld_addr_q <= 22'h00_0000;
            ld_data_q <= 8'h00;
        end else if (tbl_write && state_q == cfd_pkg::CFD_IDLE) begin
            ld_addr_q <= tbl_addr;
            ld_data_q <= tbl_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= cfd_pkg::CFD_IDLE;
            cnt_q <= 8'h00;
            write_busy_q <= 1'b0;
        end else begin
            case (state_q)
                cfd_pkg::CFD_IDLE: begin
                    if (write_start) begin
                        state_q <= cfd_pkg::CFD_WRITE;
                        cnt_q <= cfd_pkg::CFD_WRITE_LAST;
                        write_busy_q <= 1'b1;
                    end
                end
                cfd_pkg::CFD_WRITE: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= cfd_pkg::CFD_IDLE;
                        write_busy_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= cfd_pkg::CFD_IDLE;
                    write_busy_q <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // configuration cells
    // ----------------------------------------------------------------
    // reset models a blank part, all implemented bits one
    // unimplemented bits are never stored, so they read zero
    // protection slots only accept one-to-zero changes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= cfd_pkg::CFD_UNPROG;
        end else if (commit && wr_slot[3] && !wr_blocked) begin
            if (cfd_pkg::CFD_CLEAR_ONLY[wr_slot[2:0]]) begin
                cfg_q[wr_slot[2:0]] <= cfg_q[wr_slot[2:0]] & ld_data_q;
            end else begin
                cfg_q[wr_slot[2:0]] <= ld_data_q &
                    cfd_pkg::CFD_IMPL_MASK[wr_slot[2:0]];
            end
        end
    end

    // refused write flag, one cycle at the end of the timed write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_refused_q <= 1'b0;
        end else begin
            write_refused_q <= commit && wr_blocked;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // bytes mapped upward from the config base, unmapped read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en;
            if (rd_en) begin
                rd_data_q <= rd_slot[3] ? cfg_q[rd_slot[2:0]] : 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // both pins arrive from outside the clock domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_pin_sync_q <= 2'b11;
            g5_sync_q <= 2'b00;
        end else begin
            rst_pin_sync_q <= {rst_pin_sync_q[0], master_reset_pin_n};
            g5_sync_q <= {g5_sync_q[0], port_g_pin5};
        end
    end

    // ----------------------------------------------------------------
    // watchdog and bus decode
    // ----------------------------------------------------------------
    // decoders follow the stored cells plus watchdog_soft_on and bus_wait_count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            watchdog_postscale_sel_q <= 4'hF;
            watchdog_ratio_q <= 16'h8000;
            watchdog_on_q <= 1'b1;
            tbl_wait_en_q <= 1'b0;
            tbl_wait_states_q <= 2'h0;
            processor_mode_sel_q <= cfd_pkg::CFD_MODE_MCU;
        end else begin
            watchdog_postscale_sel_q <= wdt_b[cfd_pkg::CFD_B_PS_LO +: 4];
            watchdog_ratio_q <= 16'h0001 << wdt_b[cfd_pkg::CFD_B_PS_LO +: 4];
            watchdog_on_q <= wdt_b[cfd_pkg::CFD_B_WDT_FORCE] |
                             watchdog_soft_on;
            // wait field only when the bus-wait bit is clear
            tbl_wait_en_q <= !bus_b[cfd_pkg::CFD_B_BUS_WAIT];
            tbl_wait_states_q <= bus_b[cfd_pkg::CFD_B_BUS_WAIT] ?
                                 2'h0 : bus_wait_count;
            processor_mode_sel_q <= bus_b[cfd_pkg::CFD_B_MODE_LO +: 2];
        end
    end

    // ----------------------------------------------------------------
    // pin multiplexing and debug decode
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_reset_req_q <= 1'b0;
            port_g_pin5_in_q <= 1'b0;
            enh_pwm_on_port_e_q <= 1'b1;
            enh_pwm_on_port_h_q <= 1'b0;
            capture2_on_c1_q <= 1'b1;
            capture2_on_e7_q <= 1'b0;
            capture2_on_b3_q <= 1'b0;
            debug_pins_dedicated_q <= 1'b0;
            low_volt_prog_enable_q <= 1'b1;
            stack_reset_req_q <= 1'b0;
        end else begin
            // shared reset pin, port input gated off when enabled
            pin_reset_req_q <= pin_b[cfd_pkg::CFD_B_RST_PIN] &
                               !rst_pin_sync_q[1];
            port_g_pin5_in_q <= !pin_b[cfd_pkg::CFD_B_RST_PIN] &
                                g5_sync_q[1];
            enh_pwm_on_port_e_q <= pin_b[cfd_pkg::CFD_B_ENH_PWM];
            enh_pwm_on_port_h_q <= !pin_b[cfd_pkg::CFD_B_ENH_PWM];
            // capture2 routing depends on the memory mode too
            capture2_on_c1_q <= pin_b[cfd_pkg::CFD_B_CAP2];
            capture2_on_e7_q <= !pin_b[cfd_pkg::CFD_B_CAP2] &&
                bus_b[1:0] == cfd_pkg::CFD_MODE_MCU;
            capture2_on_b3_q <= !pin_b[cfd_pkg::CFD_B_CAP2] &&
                bus_b[1:0] != cfd_pkg::CFD_MODE_MCU;
            debug_pins_dedicated_q <= !dbg_b[cfd_pkg::CFD_B_DEBUG];
            low_volt_prog_enable_q <= dbg_b[cfd_pkg::CFD_B_LV_PROG];
            stack_reset_req_q <= dbg_b[cfd_pkg::CFD_B_STACK] & stack_fault;
        end
    end

    // ----------------------------------------------------------------
    // protection decode, one means protected at these outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            block_code_protect_q <= 4'h0;
            boot_code_protect_q <= 1'b0;
            eeprom_code_protect_q <= 1'b0;
            block_write_protect_q <= 4'h0;
            boot_write_protect_q <= 1'b0;
            eeprom_write_protect_q <= 1'b0;
            config_write_protect_q <= 1'b0;
        end else begin
            block_code_protect_q <= ~cpl_b[3:0];
            boot_code_protect_q <= !cph_b[cfd_pkg::CFD_B_BOOT];
            eeprom_code_protect_q <= !cph_b[cfd_pkg::CFD_B_EEP];
            block_write_protect_q <= ~wpl_b[3:0];
            boot_write_protect_q <= !wph_b[cfd_pkg::CFD_B_BOOT];
            eeprom_write_protect_q <= !wph_b[cfd_pkg::CFD_B_EEP];
            config_write_protect_q <= !wph_b[cfd_pkg::CFD_B_CFGW];
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_launch;
        state_q == cfd_pkg::CFD_IDLE && write_start;
    endsequence

    sequence s_timed_write;
        ##1 write_busy_q [*8] ##92 write_busy_q ##1 !write_busy_q;
    endsequence

    property p_write_time;
        @(posedge clk) disable iff (!rst_n) s_launch |-> s_timed_write;
    endproperty
    a_write_time: assert property (p_write_time)
        else $error("timed write length wrong");

    property p_ratio;
        @(posedge clk) disable iff (!rst_n)
        $stable(wdt_b) |=> watchdog_ratio_q ==
            (16'h0001 << $past(wdt_b[4:1]));
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("postscaler ratio mismatch");

    property p_wdt_on;
        @(posedge clk) disable iff (!rst_n)
        (wdt_b[0] || watchdog_soft_on) |=> watchdog_on_q;
    endproperty
    a_wdt_on: assert property (p_wdt_on)
        else $error("watchdog not on");

    property p_unimpl_zero;
        @(posedge clk) disable iff (!rst_n)
        (cfg_q & ~cfd_pkg::CFD_IMPL_MASK) == 64'h0000_0000_0000_0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit stored");

    property p_wait;
        @(posedge clk) disable iff (!rst_n)
        bus_b[7] |=> !tbl_wait_en_q && tbl_wait_states_q == 2'h0;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait states not suppressed");

    property p_clear_only;
        @(posedge clk) disable iff (!rst_n)
        ##1 ({cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]} &
             ~$past({cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]})) == 32'h0;
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("protection bit set back");

    property p_cfg_lock;
        @(posedge clk) disable iff (!rst_n)
        (commit && wr_blocked) |=> write_refused_q && $stable(cfg_q);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock)
        else $error("locked config write took effect");

    property p_reset_pin;
        @(posedge clk) disable iff (!rst_n)
        !pin_b[7] |=> !pin_reset_req_q;
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("pin reset while disabled");

    property p_cap2;
        @(posedge clk) disable iff (!rst_n)
        $onehot({capture2_on_c1_q, capture2_on_e7_q, capture2_on_b3_q});
    endproperty
    a_cap2: assert property (p_cap2)
        else $error("capture2 route not one-hot");

    property p_stack;
        @(posedge clk) disable iff (!rst_n)
        (stack_fault && dbg_b[0]) |=> stack_reset_req_q;
    endproperty
    a_stack: assert property (p_stack)
        else $error("stack fault reset missing");

endmodule // cfd_fuse_bank
`default_nettype wire

// File: tb.sv
// self-checking testbench for the configuration byte bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, tbl_write, write_start, rd_en, watchdog_soft_on;
    logic master_reset_pin_n, port_g_pin5, stack_fault, refd;
    logic [21:0] tbl_addr, rd_addr;
    logic [7:0] tbl_wdata, rd_data_q, d, wlast;
    logic [1:0] bus_wait_count, processor_mode_sel_q, tbl_wait_states_q;
    logic [3:0] watchdog_postscale_sel_q, block_code_protect_q;
    logic [3:0] block_write_protect_q;
    logic [15:0] watchdog_ratio_q;
    logic rd_valid_q, write_busy_q, write_refused_q, watchdog_on_q;
    logic tbl_wait_en_q, pin_reset_req_q, port_g_pin5_in_q;
    logic enh_pwm_on_port_e_q, enh_pwm_on_port_h_q, capture2_on_c1_q;
    logic capture2_on_e7_q, capture2_on_b3_q, debug_pins_dedicated_q;
    logic low_volt_prog_enable_q, stack_reset_req_q, boot_code_protect_q;
    logic eeprom_code_protect_q, boot_write_protect_q;
    logic eeprom_write_protect_q, config_write_protect_q;
    int n_fail, checks_done, seed;

    cfd_fuse_bank dut (.clk, .rst_n, .tbl_addr, .tbl_wdata, .tbl_write,
        .write_start, .rd_en, .rd_addr, .watchdog_soft_on, .bus_wait_count,
        .master_reset_pin_n, .port_g_pin5, .stack_fault, .rd_data_q,
        .rd_valid_q, .write_busy_q, .write_refused_q,
        .watchdog_postscale_sel_q, .watchdog_ratio_q, .watchdog_on_q,
        .tbl_wait_en_q, .tbl_wait_states_q, .processor_mode_sel_q,
        .pin_reset_req_q, .port_g_pin5_in_q, .enh_pwm_on_port_e_q,
        .enh_pwm_on_port_h_q, .capture2_on_c1_q, .capture2_on_e7_q,
        .capture2_on_b3_q, .debug_pins_dedicated_q, .low_volt_prog_enable_q,
        .stack_reset_req_q, .block_code_protect_q, .boot_code_protect_q,
        .eeprom_code_protect_q, .block_write_protect_q,
        .boot_write_protect_q, .eeprom_write_protect_q,
        .config_write_protect_q);

    // ----------------------------------------------------------------
    // clock, helpers and bus tasks
    // ----------------------------------------------------------------
    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // slot index to byte address, skipping the unused 300007h
    function automatic logic [21:0] sa(input int i);
        return 22'h30_0003 + 22'(i) + ((i > 3) ? 22'h1 : 22'h0);
    endfunction

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one-cycle read; the answer stands only in the following cycle
    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        rd_addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
        chk("rd_valid", 16'h0001, {15'h0, rd_valid_q});
        chk("rd_data", {8'h0, e}, {8'h0, rd_data_q});
    endtask

    // load then start; the wait is bounded so a stuck busy cannot hang
    task automatic wr(input logic [21:0] a, input logic [7:0] v);
        int n;
        tbl_addr <= a;
        tbl_wdata <= v;
        tbl_write <= 1'b1;
        @(posedge clk);
        tbl_write <= 1'b0;
        write_start <= 1'b1;
        @(posedge clk);
        write_start <= 1'b0;
        refd = 1'b0;
        n = 0;
        repeat (2) @(posedge clk);
        while (write_busy_q === 1'b1 && n < 300) begin
            @(posedge clk);
            refd = refd | write_refused_q;
            n++;
        end
        chk("busy_len", 16'(cfd_pkg::CFD_WRITE_CYCLES - 1), 16'(n));
        repeat (5) begin
            @(posedge clk);
            refd = refd | write_refused_q;
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // about 4000 cycles are needed; five times that means a hang
    initial begin
        #(20 * 20000);
        n_fail++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 11056;
        {n_fail, checks_done} = '0;
        {rst_n, tbl_write, write_start, rd_en, watchdog_soft_on} = '0;
        {port_g_pin5, stack_fault, bus_wait_count, tbl_addr} = '0;
        {rd_addr, tbl_wdata, refd} = '0;
        master_reset_pin_n = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) rd(sa(i), cfd_pkg::CFD_IMPL_MASK[i]);
        rd(22'h30_0007, 8'h00);
        chk("ratio_blank", 16'h8000, watchdog_ratio_q);
        chk("mode_blank", 16'h3, processor_mode_sel_q);
        $display("test blank state done");
        // corner codes 0000 and 1111, then random bytes
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : 8'($random(seed));
            watchdog_soft_on <= d[5];
            wr(cfd_pkg::CFD_A_WDT, d);
            wlast = d;
            chk("ps_sel", {12'h0, d[4:1]}, watchdog_postscale_sel_q);
            chk("ratio", 16'h1 << d[4:1], watchdog_ratio_q);
            chk("wdt_on", d[0] | d[5], watchdog_on_q);
            rd(cfd_pkg::CFD_A_WDT, d & 8'h1F);
        end
        $display("test watchdog done");
        wr(cfd_pkg::CFD_A_PIN, 8'h80);
        chk("pwm_h", 16'h1, enh_pwm_on_port_h_q);
        for (int k = 0; k < 8; k++) begin
            d = {k[2], 5'h0, k[1:0]};
            bus_wait_count <= 2'($random(seed));
            wr(cfd_pkg::CFD_A_BUS, d);
            chk("mode", d[1:0], processor_mode_sel_q);
            chk("wait_en", !d[7], tbl_wait_en_q);
            if (!d[7]) chk("wait", bus_wait_count, tbl_wait_states_q);
            chk("cap2_e7", d[1:0] == 2'b11, capture2_on_e7_q);
            chk("cap2_b3", d[1:0] != 2'b11, capture2_on_b3_q);
        end
        $display("test bus mode done");
        for (int k = 0; k < 4; k++) begin
            d = {k[1], 5'h0, 2'b11};
            {master_reset_pin_n, port_g_pin5} <= 2'($random(seed));
            stack_fault <= k[0];
            wr(cfd_pkg::CFD_A_PIN, d);
            chk("pin_rst", d[7] & !master_reset_pin_n, pin_reset_req_q);
            chk("g5_in", !d[7] & port_g_pin5, port_g_pin5_in_q);
            chk("pwm_e", 16'h1, enh_pwm_on_port_e_q);
            chk("cap2_c1", 16'h1, capture2_on_c1_q);
            d = {k[0], 4'h0, k[1], 1'b0, k[0] ^ k[1]};
            wr(cfd_pkg::CFD_A_DBG, d);
            chk("debug", !d[7], debug_pins_dedicated_q);
            chk("low_volt", d[2], low_volt_prog_enable_q);
            chk("stack", d[0] & stack_fault, stack_reset_req_q);
            rd(cfd_pkg::CFD_A_DBG, d & 8'h85);
        end
        $display("test pins done");
        // block 1 and block 3 bits kept at one
        wr(cfd_pkg::CFD_A_CPL, 8'hFA);
        chk("refused", 16'h0, refd);
        chk("cp_blk", 16'h5, block_code_protect_q);
        wr(cfd_pkg::CFD_A_CPL, 8'h0F);
        rd(cfd_pkg::CFD_A_CPL, 8'h0A);
        wr(cfd_pkg::CFD_A_CPH, 8'h40);
        chk("cp_eep", 16'h1, eeprom_code_protect_q);
        chk("cp_boot", 16'h0, boot_code_protect_q);
        wr(cfd_pkg::CFD_A_WPL, 8'h03);
        chk("wp_blk", 16'hC, block_write_protect_q);
        wr(cfd_pkg::CFD_A_WPH, 8'h3F);
        chk("wp_eep", 16'h1, eeprom_write_protect_q);
        chk("wp_boot", 16'h1, boot_write_protect_q);
        chk("wp_cfg", 16'h0, config_write_protect_q);
        // once the lock is set, writes to the watchdog byte and to the unused 300007h are refused
        wr(cfd_pkg::CFD_A_WPH, 8'hDF);
        chk("wp_cfg", 16'h1, config_write_protect_q);
        wr(cfd_pkg::CFD_A_WDT, ~wlast);
        chk("refused", 16'h1, refd);
        rd(cfd_pkg::CFD_A_WDT, wlast & 8'h1F);
        wr(22'h30_0007, 8'h00);
        chk("refused", 16'h1, refd);
        $display("test protection done");
        stop_test();
    end
endmodule // tb
`default_nettype wire
